/* File: src/dior_top.sv */
// Digital register bank: inputs, filter, counters, latches and mapped settings
//
// Operation
// R01: Filter setting zero off, step 100 us
// R02: Settings above 250 clamp to 25 ms
// R03: One filter setting for all inputs
// R04: Input levels in state bits 0..3
// R05: Output faults in state bits 4..5
// R06: Counter one event only, two selectable
// R07: Mode bits 6..7 select event or gate
// R08: Bits 0..3 pick gate counting clock
// R09: Clear bit rising edge clears counter
// R10: Setup and clear bits share one register
// R11: Latch captures filtered input state
// R12: Host acks latch with one bits
// R13: Bus-controller mode uses object byte positions
// R14: Event counter counts falling edges
// R15: Gate times rise to fall, saturates
// R16: Host rewrites setup with clear bit
// R17: Inputs sampled every 200 us
// R18: Latch stays set until acknowledged
`include "dior_regs.svh"
`default_nettype none
module dior_top
  import dior_pkg::*;
#(
  parameter int SAMPLE_CYC = `DIOR_SAMPLE_CYC
) (
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        can_mode,
  output var  logic [31:0] reg_rdata,
  // Pins
  input  wire logic [3:0]  din_pin,
  input  wire logic [1:0]  out_fault_pin,
  // Analog front end
  input  wire logic [15:0] adc_value,
  input  wire logic [7:0]  adc_monitor,
  // Outputs to the I/O stage
  output var  logic [1:0]  out_drive,
  output var  logic [15:0] dac_value,
  output var  logic [7:0]  afilt_cfg,
  output var  logic [7:0]  arange_cfg,
  output var  logic [15:0] alow_lim,
  output var  logic [15:0] ahigh_lim
);
  logic [5:0]    s1_q, s2_q, s3_q;   // Pin synchroniser stages
  logic [5:0]    pin_q;              // Agreed pin levels
  logic [12:0]   smp_cnt_q;          // Sample interval counter
  logic          smp_q;              // Sample strobe
  logic [7:0]    filt_set_q;         // Common filter setting
  logic [7:0]    delay_eff;          // Clamped delay
  logic [3:0]    filt;               // Filtered inputs
  logic [3:0]    filt_prev_q;        // Filtered inputs, one cycle late
  logic [3:0]    latch_q;            // Latched inputs
  logic [7:0]    ccfg_q;             // Counter setup and clear bits
  logic [15:0]   cnt1_q, cnt2_q;     // Counter values
  dior_gate_type gate_q;             // Gate measurement state
  logic [23:0]   nco_q;              // Gate clock phase
  logic [16:0]   gate_acc_q;         // Gate time accumulator
  logic [25:0]   nco_inc, nco_sum;   // Phase step and sum
  logic [16:0]   gate_nxt;           // Accumulator after this cycle
  logic [7:0]    eaddr;              // Effective register offset
  logic          wr_ccfg, clr1, clr2;
  logic [3:0]    fall, rise;
  logic          gate_mode;

  // Synchronise pins: three stages, change taken when stages two and three agree
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1_q  <= 6'h00;
      s2_q  <= 6'h00;
      s3_q  <= 6'h00;
      pin_q <= 6'h00;
    end else if (clk_en) begin
      s1_q <= {out_fault_pin, din_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & pin_q);
    end
  end

  // R17: sample strobe every interval
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      smp_cnt_q <= 13'h0000;
      smp_q     <= 1'b0;
    end else if (clk_en) begin
      smp_q <= (smp_cnt_q == 13'(SAMPLE_CYC - 1));
      if (smp_cnt_q == 13'(SAMPLE_CYC - 1)) begin
        smp_cnt_q <= 13'h0000;
      end else begin
        smp_cnt_q <= smp_cnt_q + 13'h0001;
      end
    end
  end

  // R02: clamp the delay to 25 ms
  assign delay_eff = (filt_set_q > `DIOR_FILT_MAX) ? `DIOR_FILT_MAX : filt_set_q;

  // R01 R03: one clamped setting drives every channel filter
  for (genvar i = 0; i < 4; i++) begin : g_filt
    dior_in_filter u_filt (
      .mclk   (mclk),
      .resetn (resetn),
      .clk_en (clk_en),
      .raw    (pin_q[i]),
      .sample (smp_q),
      .delay  (delay_eff),
      .filt   (filt[i])
    );
  end

  // Edge detection on filtered inputs
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      filt_prev_q <= 4'h0;
    end else if (clk_en) begin
      filt_prev_q <= filt;
    end
  end
  assign fall = filt_prev_q & ~filt;
  assign rise = ~filt_prev_q & filt;

  // R13: in bus-controller mode the address is a byte position in the object
  always_comb begin
    eaddr = reg_addr;
    if (can_mode) begin
      eaddr = 8'hFF;
      if (reg_wr) begin
        case (reg_addr)
          `DIOR_CAN_DRIVE: eaddr = `DIOR_OFF_DRIVE;
          `DIOR_CAN_AOUT:  eaddr = `DIOR_OFF_AOUT;
          default:         eaddr = 8'hFF;
        endcase
      end else begin
        case (reg_addr)
          `DIOR_CAN_STATE: eaddr = `DIOR_OFF_STATE;
          `DIOR_CAN_CNT1:  eaddr = `DIOR_OFF_CNT1;
          `DIOR_CAN_CNT2:  eaddr = `DIOR_OFF_CNT2;
          `DIOR_CAN_AIN:   eaddr = `DIOR_OFF_AIN;
          default:         eaddr = 8'hFF;
        endcase
      end
    end
  end

  // R09 R10: clears come from rising edges of bits written to the setup register
  assign wr_ccfg = reg_wr && (eaddr == `DIOR_OFF_CCFG);
  assign clr1 = wr_ccfg && reg_wdata[`DIOR_CCFG_CLR1] && !ccfg_q[`DIOR_CCFG_CLR1];
  assign clr2 = wr_ccfg && reg_wdata[`DIOR_CCFG_CLR2] && !ccfg_q[`DIOR_CCFG_CLR2];
  // R07: mode field selects gate measurement
  assign gate_mode = (ccfg_q[`DIOR_CCFG_MODE_LSB +: 2] == DIOR_M_GATE);

  // Writable registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      out_drive  <= 2'b00;
      dac_value  <= 16'h0000;
      filt_set_q <= `DIOR_RST_CFG;
      ccfg_q     <= `DIOR_RST_CFG;
      afilt_cfg  <= `DIOR_RST_CFG;
      arange_cfg <= `DIOR_RST_CFG;
      alow_lim   <= `DIOR_RST_ALOW;
      ahigh_lim  <= `DIOR_RST_AHIGH;
    end else if (clk_en && reg_wr) begin
      case (eaddr)
        `DIOR_OFF_DRIVE:  out_drive  <= reg_wdata[1:0];
        `DIOR_OFF_AOUT:   dac_value  <= reg_wdata[15:0];
        `DIOR_OFF_FILT:   filt_set_q <= reg_wdata[7:0];
        `DIOR_OFF_CCFG:   ccfg_q     <= reg_wdata[7:0];
        `DIOR_OFF_AFILT:  afilt_cfg  <= reg_wdata[7:0];
        `DIOR_OFF_ARANGE: arange_cfg <= reg_wdata[7:0];
        `DIOR_OFF_ALOW:   alow_lim   <= reg_wdata[15:0];
        `DIOR_OFF_AHIGH:  ahigh_lim  <= reg_wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // R11 R18: latch sets from the filtered level, a set beats a same-cycle ack
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      latch_q <= 4'h0;
    end else if (clk_en) begin
      // R12: acknowledge clears only channels written with one
      if (reg_wr && (eaddr == `DIOR_OFF_ACK)) begin
        latch_q <= (latch_q & ~reg_wdata[3:0]) | filt;
      end else begin
        latch_q <= latch_q | filt;
      end
    end
  end

  // R06 R14: counter one counts falling edges of input one only
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt1_q <= 16'h0000;
    end else if (clk_en) begin
      if (clr1) begin
        cnt1_q <= 16'h0000;
      end else if (fall[0]) begin
        cnt1_q <= cnt1_q + 16'h0001;
      end
    end
  end

  // R08: phase step of the selected gate counting clock
  always_comb begin
    case (ccfg_q[`DIOR_CCFG_RATE_LSB +: 4])
      4'h1:    nco_inc = `DIOR_INC(3000000);
      4'h2:    nco_inc = `DIOR_INC(187500);
      4'h3:    nco_inc = `DIOR_INC(24000000);
      4'h4:    nco_inc = `DIOR_INC(12000000);
      4'h5:    nco_inc = `DIOR_INC(6000000);
      4'h6:    nco_inc = `DIOR_INC(1500000);
      4'h7:    nco_inc = `DIOR_INC(750000);
      4'h8:    nco_inc = `DIOR_INC(375000);
      default: nco_inc = `DIOR_INC(48000000);
    endcase
  end
  assign nco_sum = {2'b00, nco_q} + nco_inc;
  // R15: accumulate whole counting-clock periods, saturate at the top
  always_comb begin
    gate_nxt = gate_acc_q + {15'h0000, nco_sum[25:24]};
    if (gate_nxt > `DIOR_GATE_MAX) begin
      gate_nxt = `DIOR_GATE_MAX;
    end
  end

  // Counter two: event count on input three or gate timing on input four
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt2_q     <= 16'h0000;
      gate_q     <= DIOR_G_IDLE;
      nco_q      <= 24'h000000;
      gate_acc_q <= 17'h00000;
    end else if (clk_en) begin
      if (!gate_mode) begin
        gate_q <= DIOR_G_IDLE;
        if (clr2) begin
          cnt2_q <= 16'h0000;
        // R14: event mode counts falling edges
        end else if (fall[2]) begin
          cnt2_q <= cnt2_q + 16'h0001;
        end
      end else begin
        case (gate_q)
          DIOR_G_IDLE: begin
            // Start timing on the rising edge
            if (rise[3]) begin
              gate_q     <= DIOR_G_RUN;
              nco_q      <= 24'h000000;
              gate_acc_q <= 17'h00000;
            end
          end
          DIOR_G_RUN: begin
            nco_q      <= nco_sum[23:0];
            gate_acc_q <= gate_nxt;
            // R15: store the result on the falling edge
            if (fall[3]) begin
              gate_q <= DIOR_G_IDLE;
              cnt2_q <= gate_acc_q[15:0];
            end
          end
          default: gate_q <= DIOR_G_IDLE;
        endcase
        if (clr2) begin
          cnt2_q <= 16'h0000;
        end
      end
    end
  end

  // Read data, registered; write-only and unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en && reg_rd) begin
      case (eaddr)
        // R04 R05: input levels low, output faults above
        `DIOR_OFF_STATE: reg_rdata <= {26'h0000000, pin_q[5:4], filt};
        `DIOR_OFF_CNT1:  reg_rdata <= {16'h0000, cnt1_q};
        `DIOR_OFF_CNT2:  reg_rdata <= {16'h0000, cnt2_q};
        `DIOR_OFF_AIN:   reg_rdata <= {16'h0000, adc_value};
        `DIOR_OFF_LATCH: reg_rdata <= {28'h0000000, latch_q};
        `DIOR_OFF_AMON:  reg_rdata <= {24'h000000, adc_monitor};
        default:         reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // Checks
  sequence s_clr1_req;
    clk_en && clr1;
  endsequence
  sequence s_gate_end;
    clk_en && gate_mode && (gate_q == DIOR_G_RUN) && fall[3] && !clr2;
  endsequence

  clamp_delay_a: assert property (@(posedge mclk) disable iff (!resetn) // R02
    ((filt_set_q <= `DIOR_FILT_MAX) || (delay_eff == `DIOR_FILT_MAX)) && (g_filt[0].u_filt.run_q < 9'h0FA))
    else $error("filter delay not clamped");
  clear_first_a: assert property (@(posedge mclk) disable iff (!resetn) // R09
    s_clr1_req |=> (cnt1_q == 16'h0000))
    else $error("counter one not cleared");
  count_fall_a: assert property (@(posedge mclk) disable iff (!resetn) // R14
    (clk_en && fall[0] && !clr1) |=> (cnt1_q == $past(cnt1_q) + 16'h0001))
    else $error("counter one missed an edge");
  count_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // R06
    (clk_en && !fall[0] && !clr1) |=> $stable(cnt1_q))
    else $error("counter one moved without an edge");
  latch_keep_a: assert property (@(posedge mclk) disable iff (!resetn) // R18
    (clk_en && latch_q[0] && !(reg_wr && eaddr == `DIOR_OFF_ACK && reg_wdata[0]))
    |=> latch_q[0])
    else $error("latch lost without ack");
  latch_set_a: assert property (@(posedge mclk) disable iff (!resetn) // R11
    (clk_en && filt[1]) |=> latch_q[1])
    else $error("latch did not capture input");
  gate_store_a: assert property (@(posedge mclk) disable iff (!resetn) // R15
    s_gate_end |=> (cnt2_q == $past(gate_acc_q[15:0])) && (gate_q == DIOR_G_IDLE))
    else $error("gate result not stored");
  filt_off_a: assert property (@(posedge mclk) disable iff (!resetn) // R01
    (clk_en && filt_set_q == 8'h00) ##1 (clk_en && filt_set_q == 8'h00)
    |-> (filt[2] == $past(pin_q[2])))
    else $error("filter off does not follow input");
  state_read_a: assert property (@(posedge mclk) disable iff (!resetn) // R05
    (clk_en && reg_rd && eaddr == `DIOR_OFF_STATE)
    |=> (reg_rdata[5:4] == $past(pin_q[5:4])) && (reg_rdata[31:6] == 26'h0000000))
    else $error("state byte fault bits wrong");
endmodule
`default_nettype wire

/* File: common/dior_regs.svh */
// Offsets, field positions, reset values and timing counts of the register bank
`ifndef DIOR_REGS_SVH
`define DIOR_REGS_SVH
// Register offsets on the register port
`define DIOR_OFF_STATE    8'h00
`define DIOR_OFF_DRIVE    8'h02
`define DIOR_OFF_CNT1     8'h04
`define DIOR_OFF_CNT2     8'h06
`define DIOR_OFF_AIN      8'h08
`define DIOR_OFF_AOUT     8'h0A
`define DIOR_OFF_FILT     8'h0C
`define DIOR_OFF_CCFG     8'h0E
`define DIOR_OFF_LATCH    8'h10
`define DIOR_OFF_ACK      8'h12
`define DIOR_OFF_AFILT    8'h16
`define DIOR_OFF_ARANGE   8'h18
`define DIOR_OFF_ALOW     8'h1A
`define DIOR_OFF_AHIGH    8'h1C
`define DIOR_OFF_AMON     8'h1F
// Byte positions inside the cyclic bus-controller object
`define DIOR_CAN_STATE    8'h00
`define DIOR_CAN_CNT1     8'h02
`define DIOR_CAN_CNT2     8'h04
`define DIOR_CAN_AIN      8'h06
`define DIOR_CAN_DRIVE    8'h00
`define DIOR_CAN_AOUT     8'h02
// Counter configuration fields
`define DIOR_CCFG_RATE_LSB 0
`define DIOR_CCFG_CLR1     4
`define DIOR_CCFG_CLR2     5
`define DIOR_CCFG_MODE_LSB 6
// Filter setting limits
`define DIOR_FILT_MAX     8'hFA
`define DIOR_FILT_STEP    9'h002
// Reset values and the gate time saturation limit
`define DIOR_RST_CFG      8'h00
`define DIOR_RST_ALOW     16'h8000
`define DIOR_RST_AHIGH    16'h7FFF
`define DIOR_GATE_MAX     17'h0FFFF
// Timing
`define DIOR_CLK_HZ       40000000
`define DIOR_SAMPLE_US    200
`define DIOR_SAMPLE_CYC   ((`DIOR_CLK_HZ / 1000000) * `DIOR_SAMPLE_US)
// Phase increment of the gate-clock generator for a rate in Hz
`define DIOR_INC(f)       26'(((64'(f)) << 24) / 64'(`DIOR_CLK_HZ))
`endif

/* File: common/dior_pkg.sv */
// Types shared by the register bank modules
`default_nettype none
package dior_pkg;
  // Gate measurement states, one-hot
  typedef enum logic [1:0] {
    DIOR_G_IDLE = 2'b01,
    DIOR_G_RUN  = 2'b10
  } dior_gate_type;
  // Operating mode of the second counter
  typedef enum logic [1:0] {
    DIOR_M_EVENT = 2'b00,
    DIOR_M_GATE  = 2'b01
  } dior_mode_type;
endpackage
`default_nettype wire

/* File: src/dior_in_filter.sv */
// Software input filter for one digital input channel
`include "dior_regs.svh"
`default_nettype none
module dior_in_filter
  import dior_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  // Channel
  input  wire logic       raw,
  input  wire logic       sample,
  input  wire logic [7:0] delay,
  output var  logic       filt
);
  logic [8:0] run_q;  // Time the input has differed, in setting steps

  // Accept a new level only after it held for the delay
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      run_q <= 9'h000;
      filt  <= 1'b0;
    end else if (clk_en) begin
      if (delay == 8'h00) begin
        // Filter off: follow the synchronised pin
        run_q <= 9'h000;
        filt  <= raw;
      end else if (sample) begin
        if (raw == filt) begin
          run_q <= 9'h000;
        end else if (run_q + `DIOR_FILT_STEP >= {1'b0, delay}) begin
          run_q <= 9'h000;
          filt  <= raw;
        end else begin
          run_q <= run_q + `DIOR_FILT_STEP;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/dior_field_model.sv */
// Field-side model: drives the input pins, output fault pins and analog values
`default_nettype none
module dior_field_model (
  // Clock
  input  wire logic        mclk,
  // Pins toward the register bank
  output var  logic [3:0]  din_pin,
  output var  logic [1:0]  out_fault_pin,
  // Analog front end values
  output var  logic [15:0] adc_value,
  output var  logic [7:0]  adc_monitor
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet pins and a fixed analog reading at start
  initial begin
    din_pin = 4'h0;
    out_fault_pin = 2'h0;
    adc_value = 16'h1234;
    adc_monitor = 8'h02;
  end

  // Set pin levels away from the sampling edge
  task set_pins(input logic [3:0] d, input logic [1:0] f);
    @(negedge mclk);
    din_pin = d;
    out_fault_pin = f;
  endtask

  // High pulse of w cycles on one channel, then low for w cycles
  task pulse(input int ch, input int w);
    @(negedge mclk);
    din_pin[ch] = 1'b1;
    repeat (w) @(negedge mclk);
    din_pin[ch] = 1'b0;
    repeat (w) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

/* File: bench/dior_top_tb.sv */
// Self-checking bench for the digital register bank
`default_nettype none
module dior_top_tb import dior_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SC = 20;                       // Shortened sample period
  logic        mclk = 1'b0;                     // 40 MHz clock
  logic        resetn, clk_en, reg_wr, reg_rd;  // Control inputs
  logic        can_mode;                        // Bus-controller addressing
  logic [7:0]  reg_addr, afilt, arange, amon;   // Address and byte outputs
  logic [31:0] reg_wdata, reg_rdata, v;         // Data and last read
  logic [3:0]  din;                             // Input pins
  logic [1:0]  flt, drive;                      // Fault pins and drives
  logic [15:0] adc, dac, alow, ahigh;           // Analog values
  int          num_errors = 0, samples_checked = 0, cycles = 0;
  int          rate_f [9] = '{3840, 240, 15, 1920, 960, 480, 120, 60, 30};

  // Clock and timeout
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 95000) begin
      num_errors++;
      final_report();
    end
  end

  dior_field_model i_field (.mclk(mclk), .din_pin(din), .out_fault_pin(flt),
    .adc_value(adc), .adc_monitor(amon));

  dior_top #(.SAMPLE_CYC(SC)) i_dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .can_mode(can_mode), .reg_rdata(reg_rdata), .din_pin(din), .out_fault_pin(flt),
    .adc_value(adc), .adc_monitor(amon), .out_drive(drive), .dac_value(dac),
    .afilt_cfg(afilt), .arange_cfg(arange), .alow_lim(alow), .ahigh_lim(ahigh));

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Wait n cycles
  task w(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One-cycle write strobe
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  // One-cycle read strobe, data taken once registered
  task rd(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask

  // Verdict and end of run
  task final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    can_mode = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    w(16);
    resetn = 1'b1;
    // Mapped settings: reset values, writes, and a write ignored while disabled
    check({16'h0, alow}, 32'h8000);
    check({16'h0, ahigh}, 32'h7FFF);
    wr(8'h16, 32'h5A);
    wr(8'h18, 32'h11);
    wr(8'h1A, 32'hE000);
    clk_en = 1'b0;
    wr(8'h1C, 32'h1234);
    clk_en = 1'b1;
    check({24'h0, afilt}, 32'h5A);
    check({24'h0, arange}, 32'h11);
    check({16'h0, alow}, 32'hE000);
    check({16'h0, ahigh}, 32'h7FFF);
    // Analog monitor and analog value on the register port
    rd(8'h1F);
    check(v, 32'h2);
    rd(8'h08);
    check(v, 32'h1234);
    // Walk one input bit and both fault bits through the state byte
    for (int i = 0; i < 4; i++) begin
      i_field.set_pins(4'(1 << i), 2'(i));
      w(8);
      rd(8'h00);
      check(v, {26'h0, 2'(i), 4'(1 << i)});
    end
    rd(8'h0E);
    check(v, 32'h0);
    // Setting 4 delays every channel alike
    i_field.set_pins(4'h0, 2'h0);
    w(8);
    wr(8'h0C, 32'h4);
    i_field.set_pins(4'hF, 2'h0);
    w(12);
    rd(8'h00);
    check(v, 32'h0);
    w(80);
    rd(8'h00);
    check(v, 32'hF);
    // Largest setting acts as 250
    wr(8'h0C, 32'hFF);
    i_field.set_pins(4'h0, 2'h0);
    w(2400);
    rd(8'h00);
    check(v, 32'hF);
    w(128);
    rd(8'h00);
    check(v, 32'h0);
    wr(8'h0C, 32'h0);
    // Latch holds until its own ack bit
    wr(8'h12, 32'hF);
    rd(8'h10);
    check(v, 32'h0);
    i_field.pulse(1, 10);
    w(8);
    rd(8'h10);
    check(v, 32'h2);
    wr(8'h12, 32'h1);
    rd(8'h10);
    check(v, 32'h2);
    wr(8'h12, 32'h2);
    rd(8'h10);
    check(v, 32'h0);
    // Event counting on input one and input three
    wr(8'h0E, 32'h30);
    wr(8'h0E, 32'h00);
    rd(8'h04);
    check(v, 32'h0);
    for (int i = 0; i < 3; i++) i_field.pulse(0, 10);
    for (int i = 0; i < 2; i++) i_field.pulse(2, 10);
    i_field.pulse(3, 10);
    w(8);
    rd(8'h04);
    check(v, 32'h3);
    rd(8'h06);
    check(v, 32'h2);
    wr(8'h0E, 32'h41);
    i_field.pulse(0, 10);
    w(8);
    rd(8'h04);
    check(v, 32'h4);
    // Clear acts on a rising bit only, setup rewritten with it
    wr(8'h0E, 32'h51);
    rd(8'h04);
    check(v, 32'h0);
    i_field.pulse(0, 10);
    wr(8'h0E, 32'h51);
    rd(8'h04);
    check(v, 32'h1);
    // Gate timing over every counting clock
    for (int r = 0; r < 9; r++) begin
      wr(8'h0E, 32'h40 | r);
      i_field.pulse(3, 800);
      rd(8'h06);
      check({31'h0, (v * 4 + 8 >= rate_f[r]) && (v * 4 <= rate_f[r] + 8)}, 32'h1);
    end
    // Long gate saturates
    wr(8'h0E, 32'h40);
    i_field.set_pins(4'h8, 2'h0);
    w(55000);
    i_field.set_pins(4'h0, 2'h0);
    w(8);
    rd(8'h06);
    check(v, 32'hFFFF);
    // Object byte positions
    can_mode = 1'b1;
    rd(8'h02);
    check(v, 32'h1);
    rd(8'h04);
    check(v, 32'hFFFF);
    rd(8'h06);
    check(v, 32'h1234);
    rd(8'h01);
    check(v, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h02, 32'hABCD);
    w(1);
    check({30'h0, drive}, 32'h2);
    check({16'h0, dac}, 32'hABCD);
    can_mode = 1'b0;
    final_report();
  end
endmodule
`default_nettype wire
